// ===== src/sbag_pkg.sv
/*
 * package for the secure boot access gate: key width, boot source
 * encoding, shared carrier structs.
 * assumes nothing of its surroundings; compiled first.
 */
package sbag_pkg;
    // ------------------------------------------------------------
    // key and scan widths
    // ------------------------------------------------------------
    localparam int KEY_W = 64;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] KEY_BITS = 7'h40;
    // neutral default key, arbitrary value, overridden per customer
    localparam logic [KEY_W-1:0] KEY_DEFAULT = 64'h0123_4567_89AB_CDEF;
    // boot pin codes
    localparam logic [1:0] BOOT_PIN_SPI_SLAVE = 2'h0;
    localparam logic [1:0] BOOT_PIN_SPI_MASTER = 2'h1;
    localparam logic [1:0] BOOT_PIN_EPROM8 = 2'h2;
    localparam logic [1:0] BOOT_PIN_ROM = 2'h3;
    // sync stages
    localparam int SYNC_STAGES = 2;
    // boot latch: last settle count, then ce edges from reset release to boot_valid
    localparam logic [1:0] SETTLE_LAST = 2'h3;
    localparam logic [2:0] BOOT_EDGES = 3'h4;

    typedef enum logic [1:0] {
        SBAG_BOOT_SPI_SLAVE,
        SBAG_BOOT_SPI_MASTER,
        SBAG_BOOT_EPROM8,
        SBAG_BOOT_ROM
    } sbag_boot_t;

    // grants handed to the rest of the processor
    typedef struct packed {
        logic emu_enable;
        logic ext_boot_enable;
        logic code_read_enable;
        logic tap_free_access;
    } sbag_grant_t;

    // one scan-path request from the test access port
    typedef struct packed {
        logic shift;
        logic tdi;
        logic update;
    } sbag_scan_t;
endpackage

// ===== src/sbag_sync.sv
/*
 * two flip-flop level synchroniser.
 * assumes the input is a level that stays stable for several clocks.
 */
`timescale 1ns/10ps
module sbag_sync (
    // clocking
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // level in and out
    input wire logic din,
    output logic dout
);
    import sbag_pkg::*;

    logic [SYNC_STAGES-1:0] ff_reg;
    logic [SYNC_STAGES-1:0] ff_next;

    // --------------------------------------------------------------
    // shift chain, only the last stage is read
    // --------------------------------------------------------------
    always_comb begin
        ff_next = ff_reg;
        if (ce) begin
            ff_next = {ff_reg[SYNC_STAGES-2:0], din};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ff_reg <= '0;
        end else begin
            ff_reg <= ff_next;
        end
    end

    assign dout = ff_reg[SYNC_STAGES-1];
endmodule

// ===== src/sbag_top.sv
/*
 * secure boot access gate: key capture on the test clock, unlock and
 * boot source decode on the processor clock.
 * assumes security_enable is a static strap; test clock may stop
 * between scans; the update strobe follows the last shift edge.
 */
// Operation
// - with security on, unauthorised reads of internal code are refused
// - with security on and locked, no external boot; fetch only internal SRAM or ROM
// - unlock key is 64 bits shifted through the test port, all compared
// - a wrong key leaves lock state unchanged and does nothing else
// - with security on, emulation and external boot stay off until a matching key arrives
// - locked device gives the test port no free access
// - boot source chosen at power-up from the two boot pins
`timescale 1ns/10ps
module sbag_top #(
    parameter logic [sbag_pkg::KEY_W-1:0] CUSTOMER_KEY = sbag_pkg::KEY_DEFAULT
) (
    // processor clock domain
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // strap and boot pins
    input wire logic security_enable,
    input wire logic [1:0] boot_source_select_pins,
    // test port domain
    input wire logic tck,
    input wire logic trst_n,
    input wire sbag_pkg::sbag_scan_t scan_in,
    // code read requests
    input wire logic code_rd_req,
    input wire logic code_rd_auth,
    input wire logic [31:0] code_rd_data_mem,
    output logic code_rd_grant,
    output logic [31:0] code_rd_data,
    // results
    output sbag_pkg::sbag_boot_t boot_source,
    output logic boot_valid,
    output logic internal_fetch_only,
    output sbag_pkg::sbag_grant_t grant,
    output logic unlocked
);
    import sbag_pkg::*;

    // ------------------------------------------------------------
    // test clock side: shift register and key compare
    // ------------------------------------------------------------
    logic [KEY_W-1:0] key_sr_reg, key_sr_next;
    logic [CNT_W-1:0] bits_reg, bits_next;
    logic key_ok_reg, key_ok_next;

    // the match is a level, not a toggle: a lone test reset must never
    // look like a fresh match on the processor side
    always_comb begin
        key_sr_next = key_sr_reg;
        bits_next = bits_reg;
        key_ok_next = key_ok_reg;
        if (scan_in.shift) begin
            key_sr_next = {scan_in.tdi, key_sr_reg[KEY_W-1:1]};
            // count saturates; extra shifts only push older bits out
            if (bits_reg != KEY_BITS) begin
                bits_next = bits_reg + 7'h01;
            end
        end else if (scan_in.update) begin
            // full 64 bits and exact match only; anything else is dropped
            if (bits_reg == KEY_BITS && key_sr_reg == CUSTOMER_KEY) begin
                key_ok_next = 1'b1;
            end
            bits_next = '0;
        end
    end

    // test clock registers, cleared only by the test reset apart from the bit count, which update also clears
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            key_sr_reg <= '0;
            bits_reg <= '0;
            key_ok_reg <= 1'b0;
        end else begin
            key_sr_reg <= key_sr_next;
            bits_reg <= bits_next;
            key_ok_reg <= key_ok_next;
        end
    end

    // ------------------------------------------------------------
    // crossings into the processor clock
    // ------------------------------------------------------------
    logic key_s, sec_s;
    logic [1:0] pins_s;

    // single-bit levels only, so two flops per bit are enough
    sbag_sync u_sync_key (.clk(clk), .arst_n(arst_n), .ce(ce),
        .din(key_ok_reg), .dout(key_s));
    sbag_sync u_sync_sec (.clk(clk), .arst_n(arst_n), .ce(ce),
        .din(security_enable), .dout(sec_s));
    sbag_sync u_sync_p0 (.clk(clk), .arst_n(arst_n), .ce(ce),
        .din(boot_source_select_pins[0]), .dout(pins_s[0]));
    sbag_sync u_sync_p1 (.clk(clk), .arst_n(arst_n), .ce(ce),
        .din(boot_source_select_pins[1]), .dout(pins_s[1]));

    // ------------------------------------------------------------
    // lock state
    // ------------------------------------------------------------
    logic unl_reg, unl_next;

    // sticky once the synchronised match is seen; a processor reset
    // alone re-opens if the test port still holds a good key
    always_comb begin
        unl_next = unl_reg;
        if (ce && key_s) begin
            unl_next = 1'b1;
        end
    end

    // lock register, only the processor reset closes it again
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            unl_reg <= 1'b0;
        end else begin
            unl_reg <= unl_next;
        end
    end

    // ------------------------------------------------------------
    // boot latch
    // ------------------------------------------------------------
    logic boot_ok_reg, boot_ok_next;
    logic sec_reg, sec_next;
    logic [1:0] settle_reg, settle_next;
    sbag_boot_t dec_reg, dec_next;
    sbag_boot_t boot_reg, boot_next;

    // pin choice latched once; the source shown follows the lock
    always_comb begin
        boot_ok_next = boot_ok_reg;
        sec_next = sec_reg;
        settle_next = settle_reg;
        dec_next = dec_reg;
        boot_next = boot_reg;
        if (ce) begin
            if (!boot_ok_reg) begin
                // settle counter waits out the synchronisers before latching
                if (settle_reg != SETTLE_LAST) begin
                    settle_next = settle_reg + 2'h1;
                end else begin
                    boot_ok_next = 1'b1;
                    sec_next = sec_s;
                    case (pins_s)
                        BOOT_PIN_SPI_SLAVE: dec_next = SBAG_BOOT_SPI_SLAVE;
                        BOOT_PIN_SPI_MASTER: dec_next = SBAG_BOOT_SPI_MASTER;
                        BOOT_PIN_EPROM8: dec_next = SBAG_BOOT_EPROM8;
                        BOOT_PIN_ROM: dec_next = SBAG_BOOT_ROM;
                        default: dec_next = SBAG_BOOT_ROM;
                    endcase
                end
            end
            // secured and locked parts may only start from internal rom;
            // lags the lock by one cycle so the source moves after it
            if (sec_next && !unl_reg) begin
                boot_next = SBAG_BOOT_ROM;
            end else begin
                boot_next = dec_next;
            end
        end
    end

    // boot registers; reset assumes a secured part until the strap is seen
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_ok_reg <= 1'b0;
            sec_reg <= 1'b1;
            settle_reg <= 2'h0;
            dec_reg <= SBAG_BOOT_ROM;
            boot_reg <= SBAG_BOOT_ROM;
        end else begin
            boot_ok_reg <= boot_ok_next;
            sec_reg <= sec_next;
            settle_reg <= settle_next;
            dec_reg <= dec_next;
            boot_reg <= boot_next;
        end
    end

    // ------------------------------------------------------------
    // code read gate
    // ------------------------------------------------------------
    logic gnt_reg, gnt_next;
    logic [31:0] rdata_reg, rdata_next;

    // no protected data leaves while locked unless code_rd_auth is set; answer frozen with ce low
    always_comb begin
        gnt_next = gnt_reg;
        rdata_next = rdata_reg;
        if (ce) begin
            gnt_next = 1'b0;
            rdata_next = '0;
            if (code_rd_req && (!sec_reg || unl_reg || code_rd_auth)) begin
                gnt_next = 1'b1;
                rdata_next = code_rd_data_mem;
            end
        end
    end

    // read answer registers, one ce cycle per accepted request, held through clocks with ce low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gnt_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            gnt_reg <= gnt_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic open_w;
    // one source for every field of grant, so they all move with the lock together
    assign open_w = !sec_reg || unl_reg;
    assign code_rd_grant = gnt_reg;
    assign code_rd_data = rdata_reg;
    assign boot_source = boot_reg;
    assign boot_valid = boot_ok_reg;
    assign internal_fetch_only = !open_w;
    assign grant = '{
        emu_enable: open_w,
        ext_boot_enable: open_w,
        code_read_enable: open_w,
        tap_free_access: open_w
    };
    assign unlocked = unl_reg;
endmodule

// ===== tb/sbag_top_sva.sv
/* port checker for the access gate.
   assumes binding into sbag_top; clk domain only. */
`timescale 1ns/10ps
module sbag_top_sva import sbag_pkg::*; (
    // clock
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // reads
    input wire logic code_rd_req,
    input wire logic code_rd_auth,
    input wire logic [31:0] code_rd_data_mem,
    input wire logic code_rd_grant,
    input wire logic [31:0] code_rd_data,
    // results
    input wire sbag_boot_t boot_source,
    input wire logic boot_valid,
    input wire logic internal_fetch_only,
    input wire sbag_grant_t grant,
    input wire logic unlocked
);
    logic [2:0] cnt_reg;
    // ------------------------------------------------------------
    // ce edges since reset, saturating where the latch happens
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            cnt_reg <= 3'h0;
        else if (ce && cnt_reg != BOOT_EDGES)
            cnt_reg <= cnt_reg + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_read_refused: assert property (
        ce && code_rd_req && internal_fetch_only && !code_rd_auth
        |=> !code_rd_grant && code_rd_data == 32'h0) else $error("locked read leaked");
    a_read_granted: assert property (
        ce && code_rd_req && (code_rd_auth || !internal_fetch_only)
        |=> code_rd_grant && code_rd_data == $past(code_rd_data_mem)) else $error("read lost");
    a_boot_internal: assert property (
        internal_fetch_only |-> !grant.ext_boot_enable && boot_source == SBAG_BOOT_ROM)
        else $error("external boot while locked");
    a_grants_locked: assert property (grant == {4{!internal_fetch_only}})
        else $error("grant out of step with lock");
    a_unlock_frees: assert property (
        unlocked |-> !internal_fetch_only && grant.tap_free_access) else $error("port still shut");
    a_lock_sticky: assert property (unlocked |=> unlocked) else $error("unlock lost");
    a_valid_time: assert property (boot_valid == (cnt_reg == BOOT_EDGES))
        else $error("boot latch at wrong time");
    a_boot_held: assert property (
        boot_valid && $stable(internal_fetch_only) && $stable(unlocked)
        |=> $stable(boot_source)) else $error("boot source moved");
    c_unlock: cover property ($rose(unlocked));
    c_refused: cover property (code_rd_req && internal_fetch_only && !code_rd_auth);
    c_granted: cover property (code_rd_grant);
    c_frozen: cover property (!ce && code_rd_grant);
endmodule
bind sbag_top sbag_top_sva i_sva (.clk, .arst_n, .ce, .code_rd_req, .code_rd_auth,
    .code_rd_data_mem, .code_rd_grant, .code_rd_data, .boot_source, .boot_valid,
    .internal_fetch_only, .grant, .unlocked);

// ===== tb/sbag_emu.sv
/* emulator model on the test port; tck runs only inside a scan.
   assumes the gate samples scan on tck rise. */
`timescale 1ns/10ps
module sbag_emu import sbag_pkg::*; (
    // test port
    output logic tck,
    output sbag_scan_t scan
);
    logic last_tdi;
    // idle port: clock still, tdi released to its pull-up level
    initial begin
        tck = 1'b0;
        last_tdi = 1'b0;
        scan = '{shift: 1'b0, tdi: 1'b1, update: 1'b0};
    end
    // n shifts then one update; a short n is a refused attempt
    task automatic scan_key(input logic [KEY_W-1:0] k, input int n);
        #7;
        for (int i = 0; i < n; i++) begin
            scan = '{shift: 1'b1, tdi: k[i], update: 1'b0};
            last_tdi = k[i];
            #15 tck = 1'b1;
            #15 tck = 1'b0;
        end
        scan = '{shift: 1'b0, tdi: ~last_tdi, update: 1'b1};
        #15 tck = 1'b1;
        #15 tck = 1'b0;
        scan = '{shift: 1'b0, tdi: 1'b1, update: 1'b0};
    endtask
endmodule

// ===== tb/sbag_top_tb.sv
/* bench for the access gate: boot decode, locked reads, key attempts.
   assumes the emulator model drives the test port. */
`timescale 1ns/10ps
module sbag_top_tb;
    import sbag_pkg::*;
    // key value is arbitrary; bit 63 set and bit 0 clear on purpose
    localparam logic [KEY_W-1:0] KEY = 64'hFEDC_BA98_7654_3210;
    logic clk, arst_n, trst_n, sec, req, auth, rd_grant, boot_valid, ifo, unlocked, tck, ce;
    logic [1:0] pins;
    logic [31:0] mem, rd_data;
    sbag_boot_t boot;
    sbag_grant_t grant;
    sbag_scan_t scan;
    int n_errors = 0;
    int samples_checked = 0;
    sbag_boot_t bmap [4] = '{SBAG_BOOT_SPI_SLAVE, SBAG_BOOT_SPI_MASTER, SBAG_BOOT_EPROM8,
        SBAG_BOOT_ROM};
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    sbag_top #(.CUSTOMER_KEY(KEY)) i_dut (.clk(clk), .arst_n(arst_n), .ce(ce),
        .security_enable(sec), .boot_source_select_pins(pins), .tck(tck), .trst_n(trst_n),
        .scan_in(scan), .code_rd_req(req), .code_rd_auth(auth), .code_rd_data_mem(mem),
        .code_rd_grant(rd_grant), .code_rd_data(rd_data), .boot_source(boot),
        .boot_valid(boot_valid), .internal_fetch_only(ifo), .grant(grant), .unlocked(unlocked));
    sbag_emu i_emu (.tck(tck), .scan(scan));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    // bounded wait; running out ends the run
    task automatic wait_for(ref logic sig, input int lim);
        int i;
        for (i = 0; i < lim && sig !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == lim)
            chk(1'b0, "wait ran out");
        if (i == lim)
            final_report();
        #1;
    endtask
    task automatic boot_up(input logic s, input logic [1:0] p);
        @(posedge clk);
        arst_n <= 1'b0;
        trst_n <= 1'b0;
        sec <= s;
        pins <= p;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        trst_n <= 1'b1;
        wait_for(boot_valid, 20);
    endtask
    task automatic rd(input logic a, input logic [31:0] d, input logic g);
        @(posedge clk);
        req <= 1'b1;
        auth <= a;
        mem <= d;
        @(posedge clk);
        req <= 1'b0;
        #1;
        chk(rd_grant === g && rd_data === (g ? d : 32'h0), "read answer");
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_boot();
        for (int p = 0; p < 4; p++) begin
            boot_up(1'b0, p[1:0]);
            chk(boot === bmap[p] && ifo === 1'b0 && grant === '1, "boot decode");
            pins <= ~p[1:0];
            repeat (4) @(posedge clk);
            chk(boot === bmap[p], "boot source moved");
            rd(1'b0, 32'hA5A5_0000 + p, 1'b1);
        end
    endtask
    task automatic t_locked();
        boot_up(1'b1, BOOT_PIN_EPROM8);
        chk(boot === SBAG_BOOT_ROM && ifo === 1'b1, "external boot open");
        chk(grant === '0 && unlocked === 1'b0, "locked port open");
        rd(1'b0, 32'h1234_5678, 1'b0);
        rd(1'b1, 32'h9ABC_DEF0, 1'b1);
        // freeze right after a granted read: the answer must stand
        @(posedge clk);
        req <= 1'b1;
        auth <= 1'b1;
        mem <= 32'h5A5A_C3C3;
        @(posedge clk);
        req <= 1'b0;
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(rd_grant === 1'b1 && rd_data === 32'h5A5A_C3C3, "read not held");
        @(posedge clk);
        ce <= 1'b1;
        auth <= 1'b0;
        @(posedge clk);
        #1;
        chk(rd_grant === 1'b0 && rd_data === 32'h0, "grant stood too long");
    endtask
    task automatic t_keys();
        i_emu.scan_key(KEY ^ 64'h8000_0000_0000_0000, 64);
        repeat (10) @(posedge clk);
        chk(unlocked === 1'b0 && grant === '0, "wrong key took");
        i_emu.scan_key(KEY >> 1, 63);
        repeat (10) @(posedge clk);
        chk(unlocked === 1'b0, "short scan took");
        ce <= 1'b0;
        i_emu.scan_key(KEY, 64);
        repeat (10) @(posedge clk);
        chk(unlocked === 1'b0, "unlocked while frozen");
        ce <= 1'b1;
        wait_for(unlocked, 20);
        // boot source follows the lock one cycle later
        @(posedge clk);
        #1;
        chk(grant === '1 && ifo === 1'b0 && boot === SBAG_BOOT_EPROM8, "no unlock");
        rd(1'b0, 32'h0F0F_F0F0, 1'b1);
        i_emu.scan_key(~KEY, 64);
        repeat (10) @(posedge clk);
        chk(unlocked === 1'b1, "unlock dropped");
    endtask
    initial begin
        arst_n = 1'b0;
        trst_n = 1'b0;
        ce = 1'b1;
        sec = 1'b1;
        pins = 2'h0;
        req = 1'b0;
        auth = 1'b0;
        mem = 32'h0;
        t_boot();
        t_locked();
        t_keys();
        final_report();
    end
endmodule
